/* File: ddr2_init_and_activate.sv */
// Notes on behaviour
// - mode registers change only on a load mode command and hold until reloaded.
// - with CKE low, outputs stay disabled and termination stays off.
// - next, reset the DLL through the mode register, A8 high; lock takes 200.
// - ready for normal access 200 cycles after the DLL reset command.
// - A10 high on precharge selects all banks; bank address picks the register.
//
// The address map and strobed register access were chosen for this implementation.
`include "ddr2_init_regs.svh"
`default_nettype none
module ddr2_init_and_activate #(
  parameter int unsigned POWERUP_CYC = `POWERUP_CYC
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // command pins, sampled on the command clock
  input  wire logic        cke,
  input  wire logic        odt,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [2:0]  ba,
  input  wire logic [13:0] addr,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // device state
  output logic             out_enable,
  output logic             term_enable,
  output logic             dev_ready,
  output logic      [7:0]  bank_open
);

  // ****************************************************************
  // command decode
  // ****************************************************************

  // one-hot of a bank address, shared by activate and precharge paths
  function automatic logic [7:0] bank_hit(input logic [2:0] b);
    logic [7:0] h;
    h = 8'h00;
    h[b] = 1'b1;
    return h;
  endfunction

  // with CKE low the device takes no command at all
  wire       cmd_ok  = cke & ~cs_n;
  wire       cmd_any = cmd_ok & ~(ras_n & cas_n & we_n);
  wire       is_act  = cmd_ok & ~ras_n &  cas_n &  we_n;
  wire       is_rd   = cmd_ok &  ras_n & ~cas_n &  we_n;
  wire       is_wr   = cmd_ok &  ras_n & ~cas_n & ~we_n;
  wire       is_pre  = cmd_ok & ~ras_n &  cas_n & ~we_n;
  wire       is_ref  = cmd_ok & ~ras_n & ~cas_n &  we_n;
  wire       is_lm   = cmd_ok & ~ras_n & ~cas_n & ~we_n;
  wire       is_acc  = is_rd | is_wr;
  wire [7:0] ba_hit  = bank_hit(ba);
  wire       pre_all = is_pre & addr[10];
  wire ddr2_init_pkg::mode_sel_t lm_sel = ddr2_init_pkg::mode_sel_t'(ba[1:0]);

  // ****************************************************************
  // state
  // ****************************************************************
  ddr2_init_pkg::init_state_t state_reg;
  ddr2_init_pkg::init_state_t state_next;
  logic [12:0]           mode_reg [4];
  logic                  check_en_reg;
  logic [`VIOL_W-1:0]    viol_reg;
  logic [`VIOL_W-1:0]    viol_next;
  logic [`VIOL_W-1:0]    viol_set;
  logic [15:0]           pwr_cnt_reg;
  logic [7:0]            wait_cnt_reg;
  logic [1:0]            ref_cnt_reg;
  logic [7:0]            dll_cnt_reg;
  logic                  dll_run_reg;
  logic [3:0]            mrd_cnt_reg;
  logic [3:0]            odt_cnt_reg;
  logic [7:0]            rrd_cnt_reg;
  logic [7:0]            faw_reg [`FAW_SLOTS];
  logic                  cke_prev_reg;
  logic [31:0]           rdata_reg;
  logic                  out_en_reg;
  logic                  term_reg;
  logic [7:0]            rcd_ok;
  logic [7:0]            rc_ok;
  logic [`FAW_SLOTS-1:0] faw_busy;
  logic                  step;

  // ****************************************************************
  // per-bank open state and row timers
  // ****************************************************************
  genvar gb;
  generate
    for (gb = 0; gb < 8; gb++) begin : g_bank
      bank_timer u_bank (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .act      (is_act & ba_hit[gb]),
        .pre      (is_pre & (addr[10] | ba_hit[gb])),
        .is_open  (bank_open[gb]),
        .rcd_ok   (rcd_ok[gb]),
        .rc_ok    (rc_ok[gb])
      );
    end
  endgenerate

  wire open_sel   = bank_open[ba];
  wire banks_idle = ~|bank_open;

  // ****************************************************************
  // initialization sequence tracker
  // ****************************************************************

  // which command moves the sequence on from each step
  always_comb begin
    step = 1'b0;
    case (state_reg)
      ddr2_init_pkg::st_cke_wait: step = pre_all;
      ddr2_init_pkg::st_emr2:     step = is_lm & (lm_sel == ddr2_init_pkg::sel_emr2);
      ddr2_init_pkg::st_emr3:     step = is_lm & (lm_sel == ddr2_init_pkg::sel_emr3);
      ddr2_init_pkg::st_emr_dll:
        step = is_lm & (lm_sel == ddr2_init_pkg::sel_emr) & ~addr[0];
      ddr2_init_pkg::st_mr_dll:
        step = is_lm & (lm_sel == ddr2_init_pkg::sel_mr) & addr[8];
      ddr2_init_pkg::st_pre2:     step = pre_all;
      ddr2_init_pkg::st_ref:
        step = is_lm & (lm_sel == ddr2_init_pkg::sel_mr) & ~addr[8]
             & (ref_cnt_reg == 2'(`REF_MIN_COUNT));
      ddr2_init_pkg::st_ocd_dflt:
        step = is_lm & (lm_sel == ddr2_init_pkg::sel_emr) & (addr[9:7] == 3'h7);
      ddr2_init_pkg::st_ocd_exit:
        step = is_lm & (lm_sel == ddr2_init_pkg::sel_emr) & (addr[9:7] == 3'h0);
      default:                    step = 1'b0;
    endcase
  end

  wire in_power = (state_reg == ddr2_init_pkg::st_power);
  wire in_init  = ~in_power & (state_reg != ddr2_init_pkg::st_done);
  wire in_ref   = (state_reg == ddr2_init_pkg::st_ref);
  wire cke_rise = cke & ~cke_prev_reg;

  // steps advance in enum order; power leaves on the rising CKE
  assign state_next = (in_power & cke_rise) ? ddr2_init_pkg::st_cke_wait :
                      (in_init & step) ? ddr2_init_pkg::init_state_t'(state_reg + 4'h1) :
                      state_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= ddr2_init_pkg::st_power;
      cke_prev_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cke_prev_reg <= cke;
    end
  end

  // power-up idle time and CKE-to-precharge wait, both saturating
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_cnt_reg  <= 16'h0000;
      wait_cnt_reg <= 8'h00;
      ref_cnt_reg  <= 2'h0;
    end else begin
      if (in_power && pwr_cnt_reg != 16'(POWERUP_CYC)) begin
        pwr_cnt_reg <= pwr_cnt_reg + 16'h0001;
      end
      if (in_power) begin
        wait_cnt_reg <= 8'(`CKE_PRE_CYC - 1);
      end else if (wait_cnt_reg != 8'h00) begin
        wait_cnt_reg <= wait_cnt_reg - 8'h01;
      end
      if (in_ref && is_ref && ref_cnt_reg != 2'(`REF_MIN_COUNT)) begin
        ref_cnt_reg <= ref_cnt_reg + 2'h1;
      end
    end
  end

  // ****************************************************************
  // mode registers, DLL lock and termination hold-off
  // ****************************************************************

  // only a load mode command writes them; the array is untouched
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        mode_reg[i] <= `MODE_RESET;
      end
    end else if (is_lm) begin
      mode_reg[lm_sel] <= addr[12:0];
    end
  end

  wire dll_locked = dll_run_reg & (dll_cnt_reg == 8'h00);
  wire rtt_on     = mode_reg[ddr2_init_pkg::sel_emr][2] | mode_reg[ddr2_init_pkg::sel_emr][6];

  // DLL restarts on every reset load; disabling it drops the lock
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dll_run_reg <= 1'b0;
      dll_cnt_reg <= 8'h00;
      odt_cnt_reg <= 4'h0;
      mrd_cnt_reg <= 4'h0;
    end else begin
      if (is_lm && lm_sel == ddr2_init_pkg::sel_mr && addr[8]) begin
        dll_run_reg <= 1'b1;
        dll_cnt_reg <= 8'(`DLL_LOCK_CYC - 1);
      end else if (is_lm && lm_sel == ddr2_init_pkg::sel_emr && addr[0]) begin
        dll_run_reg <= 1'b0;
      end else if (dll_cnt_reg != 8'h00) begin
        dll_cnt_reg <= dll_cnt_reg - 8'h01;
      end
      if (is_lm && lm_sel == ddr2_init_pkg::sel_emr && (addr[2] | addr[6])) begin
        odt_cnt_reg <= 4'(`ODT_WAIT_CYC - 1);
      end else if (odt_cnt_reg != 4'h0) begin
        odt_cnt_reg <= odt_cnt_reg - 4'h1;
      end
      if (is_lm) begin
        mrd_cnt_reg <= 4'(`T_MRD_CYC - 1);
      end else if (mrd_cnt_reg != 4'h0) begin
        mrd_cnt_reg <= mrd_cnt_reg - 4'h1;
      end
    end
  end

  // ****************************************************************
  // activate spacing across banks
  // ****************************************************************

  // a slot holds one activate for the length of the window
  generate
    for (gb = 0; gb < `FAW_SLOTS; gb++) begin : g_faw
      assign faw_busy[gb] = (faw_reg[gb] != 8'h00);
    end
  endgenerate

  // lowest free slot takes the new activate
  function automatic logic [1:0] free_slot(input logic [`FAW_SLOTS-1:0] busy);
    logic [1:0] s;
    s = 2'h0;
    for (int i = `FAW_SLOTS - 1; i >= 0; i--) begin
      if (!busy[i]) begin
        s = 2'(i);
      end
    end
    return s;
  endfunction

  wire [1:0] faw_pick = free_slot(faw_busy);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rrd_cnt_reg <= 8'h00;
      for (int i = 0; i < `FAW_SLOTS; i++) begin
        faw_reg[i] <= 8'h00;
      end
    end else begin
      rrd_cnt_reg <= is_act ? 8'(`RRD_CYC - 1) :
                     (rrd_cnt_reg != 8'h00) ? rrd_cnt_reg - 8'h01 : 8'h00;
      for (int i = 0; i < `FAW_SLOTS; i++) begin
        if (is_act && !(&faw_busy) && faw_pick == 2'(i)) begin
          faw_reg[i] <= 8'(`FAW_CYC - 1);
        end else if (faw_reg[i] != 8'h00) begin
          faw_reg[i] <= faw_reg[i] - 8'h01;
        end
      end
    end
  end

  // ****************************************************************
  // checks on what the controller drives
  // ****************************************************************
  assign viol_set[`V_RSVD]      = is_lm & (ba[2] | addr[13]);
  assign viol_set[`V_LM_BUSY]   = is_lm & ~banks_idle;
  assign viol_set[`V_MRD]       = cmd_any & (mrd_cnt_reg != 4'h0);
  assign viol_set[`V_ORDER]     = in_init & cmd_any & ~step & ~(in_ref & is_ref);
  assign viol_set[`V_CKE_DROP]  = in_init & ~cke;
  assign viol_set[`V_EARLY]     = (in_power & cke_rise & (pwr_cnt_reg < 16'(POWERUP_CYC)))
                                | ((state_reg == ddr2_init_pkg::st_cke_wait) & pre_all
                                   & (wait_cnt_reg != 8'h00));
  assign viol_set[`V_ACT_OPEN]  = is_act & open_sel;
  assign viol_set[`V_RC]        = is_act & ~rc_ok[ba];
  assign viol_set[`V_RRD]       = is_act & (rrd_cnt_reg != 8'h00);
  assign viol_set[`V_FAW]       = is_act & (&faw_busy);
  assign viol_set[`V_CLOSED]    = is_acc & ~open_sel;
  assign viol_set[`V_RCD]       = is_acc & open_sel & ~rcd_ok[ba];
  assign viol_set[`V_ODT]       = odt & (odt_cnt_reg != 4'h0);
  assign viol_set[`V_NOT_READY] = (is_acc | is_act) & ~dev_ready;

  // ****************************************************************
  // register port
  // ****************************************************************
  wire wr_ctrl = reg_wr & (reg_addr == `OFS_CTRL);
  wire wr_viol = reg_wr & (reg_addr == `OFS_VIOL);
  wire is_mode = (reg_addr[7:4] == 4'(`OFS_MODE_BASE >> 4));

  // a new event beats a clear in the same cycle
  assign viol_next = (viol_reg & ~(wr_viol ? reg_wdata[`VIOL_W-1:0] : `VIOL_RESET))
                   | (viol_set & {`VIOL_W{check_en_reg}});

  wire [31:0] status_word = {16'h0000, bank_open, 1'b0, cke, dev_ready, dll_locked,
                             4'(state_reg)};
  wire [31:0] rd_mux = (reg_addr == `OFS_CTRL)   ? {31'h00000000, check_en_reg} :
                       (reg_addr == `OFS_STATUS) ? status_word :
                       (reg_addr == `OFS_VIOL)   ? {18'h00000, viol_reg} :
                       is_mode ? {19'h00000, mode_reg[reg_addr[3:2]]} : 32'h00000000;

  // unmapped reads answer zero; read data stands one cycle only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      check_en_reg <= `CTRL_RESET;
      viol_reg     <= `VIOL_RESET;
      rdata_reg    <= 32'h00000000;
    end else begin
      if (wr_ctrl) begin
        check_en_reg <= reg_wdata[`CTRL_CHECK_EN];
      end
      viol_reg  <= viol_next;
      rdata_reg <= reg_rd ? rd_mux : 32'h00000000;
    end
  end

  // ****************************************************************
  // device outputs
  // ****************************************************************

  // termination only after the hold-off, and never while CKE is low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_en_reg <= 1'b0;
      term_reg   <= 1'b0;
    end else begin
      out_en_reg <= cke & ~mode_reg[ddr2_init_pkg::sel_emr][12];
      term_reg   <= cke & odt & rtt_on & (odt_cnt_reg == 4'h0);
    end
  end

  assign reg_rdata   = rdata_reg;
  assign out_enable  = out_en_reg;
  assign term_enable = term_reg;
  assign dev_ready   = (state_reg == ddr2_init_pkg::st_done) & dll_locked;

endmodule
`default_nettype wire

/* File: ddr2_init_regs.svh */
`ifndef DDR2_INIT_REGS_SVH
`define DDR2_INIT_REGS_SVH

// ****************************************************************
// register map, byte addresses of 32-bit words
// ****************************************************************
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_VIOL        8'h08
`define OFS_MODE_BASE   8'h10
`define CTRL_CHECK_EN   0
`define CTRL_RESET      1'b1
`define STAT_STATE_LSB  0
`define STAT_DLL_LOCK   4
`define STAT_READY      5
`define STAT_CKE        6
`define STAT_OPEN_LSB   8
`define MODE_RESET      13'h0000

// ****************************************************************
// violation flag positions, sticky, write one to clear
// ****************************************************************
`define V_RSVD          0
`define V_LM_BUSY       1
`define V_MRD           2
`define V_ORDER         3
`define V_CKE_DROP      4
`define V_EARLY         5
`define V_ACT_OPEN      6
`define V_RC            7
`define V_RRD           8
`define V_FAW           9
`define V_CLOSED        10
`define V_RCD           11
`define V_ODT           12
`define V_NOT_READY     13
`define VIOL_W          14
`define VIOL_RESET      14'h0000

// ****************************************************************
// timing: figures in their own unit, cycles derived at 100 MHz
// ****************************************************************
`define CLK_PERIOD_PS   10000
`define MIN_CYC(ns)     ((((ns) * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define T_POWERUP_NS    200000
`define POWERUP_CYC     `MIN_CYC(`T_POWERUP_NS)
`define T_CKE_PRE_NS    400
`define CKE_PRE_CYC     `MIN_CYC(`T_CKE_PRE_NS)
`define DLL_LOCK_CYC    200
`define T_MRD_CYC       2
`define ODT_WAIT_CYC    8
`define REF_MIN_COUNT   2
`define T_RCD_NS        15
`define RCD_CYC         `MIN_CYC(`T_RCD_NS)
`define T_RC_NS         55
`define RC_CYC          `MIN_CYC(`T_RC_NS)
`define T_RRD_NS        10
`define RRD_CYC         `MIN_CYC(`T_RRD_NS)
`define T_FAW_NS        45
`define FAW_CYC         `MIN_CYC(`T_FAW_NS)
`define FAW_SLOTS       4

`endif

/* File: ddr2_init_pkg.sv */
`default_nettype none
package ddr2_init_pkg;

  // ****************************************************************
  // initialization progress, in the order the steps must come
  // ****************************************************************
  typedef enum logic [3:0] {
    st_power,
    st_cke_wait,
    st_emr2,
    st_emr3,
    st_emr_dll,
    st_mr_dll,
    st_pre2,
    st_ref,
    st_ocd_dflt,
    st_ocd_exit,
    st_done
  } init_state_t;

  // target of a mode load, from the bank address
  typedef enum logic [1:0] {
    sel_mr,
    sel_emr,
    sel_emr2,
    sel_emr3
  } mode_sel_t;

endpackage
`default_nettype wire

/* File: bank_timer.sv */
`include "ddr2_init_regs.svh"
`default_nettype none
module bank_timer (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // commands aimed at this bank
  input  wire logic act,
  input  wire logic pre,
  // bank state
  output logic      is_open,
  output logic      rcd_ok,
  output logic      rc_ok
);

  logic       open_reg;
  logic [7:0] rcd_reg;
  logic [7:0] rc_reg;

  // counters load at the activate and reach zero on the edge before the first legal one
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      open_reg <= 1'b0;
      rcd_reg  <= 8'h00;
      rc_reg   <= 8'h00;
    end else begin
      if (act) begin
        open_reg <= 1'b1;
        rcd_reg  <= 8'(`RCD_CYC - 1);
        rc_reg   <= 8'(`RC_CYC - 1);
      end else begin
        if (pre) begin
          open_reg <= 1'b0;
        end
        if (rcd_reg != 8'h00) begin
          rcd_reg <= rcd_reg - 8'h01;
        end
        if (rc_reg != 8'h00) begin
          rc_reg <= rc_reg - 8'h01;
        end
      end
    end
  end

  assign is_open = open_reg;
  assign rcd_ok  = (rcd_reg == 8'h00);
  assign rc_ok   = (rc_reg == 8'h00);

endmodule
`default_nettype wire

/* File: ddr2_chk_checker.sv */
`default_nettype none
module ddr2_chk (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // command pins
  input wire logic        cke,
  input wire logic        odt,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [2:0]  ba,
  input wire logic [13:0] addr,
  // register port and state
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        out_enable,
  input wire logic        term_enable,
  input wire logic        dev_ready,
  input wire logic [7:0]  bank_open
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // ********
  // decode
  // ********
  wire [2:0] op = {ras_n, cas_n, we_n};
  wire       tk = cke && !cs_n;
  wire       lm = tk && op == 3'b000;
  // edges since dll reset, held at the top so it never wraps back
  logic [7:0] dll_cnt_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      dll_cnt_reg <= 8'h00;
    else if (lm && ba[1:0] == 2'b00 && addr[8])
      dll_cnt_reg <= 8'h01;
    else if (dll_cnt_reg != 8'h00 && dll_cnt_reg != 8'hff)
      dll_cnt_reg <= dll_cnt_reg + 8'h01;
  end
  // ********
  // properties
  // ********
  a_cke_quiet: assert property (!cke |=> !out_enable && !term_enable)
    else $error("drive or termination on with cke low");
  a_odt_off: assert property (!odt |=> !term_enable)
    else $error("termination on with odt low");
  a_lock_wait: assert property (dev_ready |-> dll_cnt_reg >= 8'hc8)
    else $error("ready before lock time");
  a_dll_drop: assert property (lm && ba[1:0] == 2'b01 && addr[0] |=> !dev_ready)
    else $error("ready kept after dll disable");
  a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside slot");
  a_act_open: assert property (tk && op == 3'b011 |=> bank_open[$past(ba)])
    else $error("activated bank not open");
  a_pre_all: assert property (tk && op == 3'b010 && addr[10] |=> bank_open == 8'h00)
    else $error("banks open after precharge all");
  a_pre_one: assert property (tk && op == 3'b010 && !addr[10] |=> !bank_open[$past(ba)])
    else $error("bank open after precharge");
  a_open_hold: assert property (!tk |=> $stable(bank_open))
    else $error("bank state moved with no command");
  c_act: cover property (tk && op == 3'b011);
  c_ready: cover property ($rose(dev_ready));
  c_term: cover property (term_enable);
endmodule
bind ddr2_init_and_activate ddr2_chk u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .cke(cke), .odt(odt), .cs_n(cs_n), .ras_n(ras_n),
  .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .out_enable(out_enable), .term_enable(term_enable), .dev_ready(dev_ready),
  .bank_open(bank_open));
`default_nettype wire

/* File: ctrl_model.sv */
`include "ddr2_init_regs.svh"
`default_nettype none
module ctrl_model #(
  parameter int PWR = 50
) (
  // clock
  input  wire logic        core_clk,
  // command pins toward the device
  output var logic         cke   = 1'b0,
  output var logic         odt   = 1'b0,
  output var logic         cs_n  = 1'b1,
  output var logic         ras_n = 1'b1,
  output var logic         cas_n = 1'b1,
  output var logic         we_n  = 1'b1,
  output var logic [2:0]   ba    = 3'h0,
  output var logic [13:0]  addr  = 14'h0
);
  timeunit 1ns;
  timeprecision 100ps;
  // deselect; address lines wander since nothing may sample them
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge core_clk);
      cs_n <= 1'b1;
      {ras_n, cas_n, we_n} <= 3'b111;
      ba <= ~ba;
      addr <= ~addr;
    end
  endtask
  // one command for one edge, then n deselect cycles
  task automatic cmd(input logic [2:0] c, input logic [2:0] b, input logic [13:0] a,
                     input int n);
    @(posedge core_clk);
    cs_n <= 1'b0;
    {ras_n, cas_n, we_n} <= c;
    ba <= b;
    addr <= a & 14'h1fff;
    idle(n);
  endtask
  // level pins, changed just after an edge
  task automatic set_pins(input logic k, input logic o);
    @(posedge core_clk);
    cke <= k;
    odt <= o;
  endtask
  // full power-up order; loads spaced three edges to clear tMRD
  task automatic init_seq(input logic [13:0] e2, input logic [13:0] mr,
                          input logic [13:0] em);
    idle(PWR + 5);
    cke <= 1'b1;
    idle(`CKE_PRE_CYC + 2);
    cmd(3'b010, 3'h0, 14'h0400, 2);
    cmd(3'b000, 3'h2, e2, 2);
    cmd(3'b000, 3'h3, 14'h0000, 2);
    cmd(3'b000, 3'h1, 14'h0000, 2);
    cmd(3'b000, 3'h0, 14'h0100, 2);
    cmd(3'b010, 3'h0, 14'h0400, 2);
    cmd(3'b001, 3'h0, 14'h0000, 2);
    cmd(3'b001, 3'h0, 14'h0000, 2);
    cmd(3'b000, 3'h0, mr, 2);
    cmd(3'b000, 3'h1, em | 14'h0380, 2);
    cmd(3'b000, 3'h1, em, 2);
  endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
`include "ddr2_init_regs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  // short power-up idle keeps the run brief
  localparam int PWR = 50;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cke, odt, cs_n, ras_n, cas_n, we_n;
  logic [2:0]  ba;
  logic [13:0] addr, e2, row;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        out_enable, term_enable, dev_ready;
  logic [7:0]  bank_open;
  int          n_mismatch = 0;
  int          check_count = 0;
  wire [2:0]   op = {ras_n, cas_n, we_n};
  always #5 core_clk = ~core_clk;
  ddr2_init_and_activate #(.POWERUP_CYC(PWR)) DUT (
    .core_clk(core_clk), .rst_n(rst_n), .cke(cke), .odt(odt), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .out_enable(out_enable), .term_enable(term_enable), .dev_ready(dev_ready),
    .bank_open(bank_open));
  ctrl_model #(.PWR(PWR)) u_ctrl (
    .core_clk(core_clk), .cke(cke), .odt(odt), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr));
  // ********
  // reference model, watches the pins like the device does
  // ********
  int          cyc = 0;
  int          t_any = -100;
  int          t_dll = 0;
  int          last_act [8] = '{default: -100};
  int          faw [$];
  logic [7:0]  m_open = 8'h00;
  logic [13:0] m_viol = 14'h0000;
  always @(posedge core_clk) begin
    cyc++;
    if (!rst_n)
      m_open = 8'h00;
    else if (cke && !cs_n) begin
      if (op == 3'b011) begin
        m_viol[`V_ACT_OPEN] |= m_open[ba];
        m_viol[`V_RC] |= (cyc - last_act[ba] < `RC_CYC);
        m_viol[`V_RRD] |= (cyc - t_any < `RRD_CYC);
        // an over-limit activate is not counted in the window
        if (faw.size() == 4 && cyc - faw[0] < `FAW_CYC)
          m_viol[`V_FAW] = 1'b1;
        else
          faw.push_back(cyc);
        if (faw.size() > 4)
          void'(faw.pop_front());
        m_open[ba] = 1'b1;
        last_act[ba] = cyc;
        t_any = cyc;
      end
      if (op[2:1] == 2'b10) begin
        m_viol[`V_CLOSED] |= !m_open[ba];
        m_viol[`V_RCD] |= m_open[ba] && (cyc - last_act[ba] < `RCD_CYC);
      end
      if (op == 3'b010)
        m_open = addr[10] ? 8'h00 : m_open & ~(8'h01 << ba);
      if (op == 3'b000 && ba[1:0] == 2'b00 && addr[8])
        t_dll = cyc;
    end
  end
  // ********
  // compare, register and closing tasks
  // ********
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk_word(reg_rdata, exp);
  endtask
  task automatic results();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // bank state follows the model every cycle
  always @(negedge core_clk) if (rst_n) chk_word({24'h0, bank_open}, {24'h0, m_open});
  // watchdog, well beyond the expected run of under a thousand cycles
  initial begin
    repeat (6000) @(posedge core_clk);
    n_mismatch++;
    results();
  end
  // ********
  // main sequence
  // ********
  initial begin
    void'($urandom(32'h40d90273));
    e2 = 14'(($urandom & 1) << 7);
    row = 14'($urandom);
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    reg_check(`OFS_CTRL, 32'h1);
    reg_check(`OFS_STATUS, 32'h0);
    for (int i = 0; i < 4; i++) reg_check(`OFS_MODE_BASE + 8'(4 * i), 32'h0);
    reg_check(8'h40, 32'h0);
    u_ctrl.cmd(3'b011, 3'h1, row, 1);
    chk_flag(out_enable, 1'b0);
    u_ctrl.init_seq(e2, 14'h0432, 14'h0004);
    while (cyc < t_dll + 198) @(negedge core_clk);
    chk_flag(dev_ready, 1'b0);
    @(negedge core_clk);
    chk_flag(dev_ready, 1'b1);
    reg_write(`OFS_MODE_BASE, 32'h1fff);
    reg_check(`OFS_STATUS, 32'h7a);
    reg_check(`OFS_MODE_BASE, 32'h0432);
    reg_check(`OFS_MODE_BASE + 8'h04, 32'h0004);
    reg_check(`OFS_MODE_BASE + 8'h08, {18'h0, e2});
    reg_check(`OFS_MODE_BASE + 8'h0c, 32'h0);
    reg_check(`OFS_VIOL, 32'h0);
    chk_flag(out_enable, 1'b1);
    u_ctrl.set_pins(1'b1, 1'b1);
    repeat (2) @(negedge core_clk);
    chk_flag(term_enable, 1'b1);
    u_ctrl.set_pins(1'b1, 1'b0);
    repeat (2) @(negedge core_clk);
    chk_flag(term_enable, 1'b0);
    // early read, legal write, act to open bank, read of closed bank
    u_ctrl.cmd(3'b011, 3'h0, row, 0);
    u_ctrl.cmd(3'b101, 3'h0, 14'h0000, 0);
    u_ctrl.cmd(3'b100, 3'h0, 14'h0000, 0);
    u_ctrl.cmd(3'b011, 3'h0, row, 0);
    u_ctrl.cmd(3'b101, 3'h7, 14'h0000, 2);
    reg_check(`OFS_VIOL, {18'h0, m_viol});
    reg_write(`OFS_VIOL, 32'h3fff);
    m_viol = 14'h0000;
    u_ctrl.cmd(3'b010, 3'h0, 14'h0400, 8);
    // six back-to-back activates: fifth too early, sixth just in time
    for (int b = 1; b <= 6; b++) u_ctrl.cmd(3'b011, 3'(b), row, 0);
    u_ctrl.cmd(3'b010, 3'h3, 14'h0000, 2);
    reg_check(`OFS_VIOL, {18'h0, m_viol});
    u_ctrl.cmd(3'b010, 3'h0, 14'h0400, 2);
    u_ctrl.cmd(3'b000, 3'h1, 14'h0005, 2);
    chk_flag(dev_ready, 1'b0);
    // recording off: a closed-bank read must leave only the old flag
    reg_write(`OFS_CTRL, 32'h0);
    u_ctrl.cmd(3'b101, 3'h2, 14'h0000, 2);
    reg_check(`OFS_VIOL, 32'(1 << `V_FAW));
    u_ctrl.set_pins(1'b0, 1'b0);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    reg_check(`OFS_MODE_BASE + 8'h04, 32'h0);
    reg_check(`OFS_CTRL, 32'h1);
    chk_flag(out_enable, 1'b0);
    results();
  end
endmodule
`default_nettype wire
